// File: rtl/timer_pkg.sv
// Purpose: shared constants and types of the eight-bit timer core
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes:   register indices are word indices; byte address is index times four
package timer_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_COUNT = 10'h0EA;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h0EB;
    localparam logic [IDX_W-1:0] IDX_CC0 = 10'h0ED;
    localparam logic [IDX_W-1:0] IDX_FLAG = 10'h0F0;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0F1;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0F2;

    // ----------------------------------------------------------------
    // control field layout and reset values
    // ----------------------------------------------------------------
    localparam int DIV_LSB = 5;
    localparam int DIV_W = 3;
    localparam int START_BIT = 4;
    localparam int OVERFLOW_IRQ_MASK_BIT = 3;
    localparam int CLR_BIT = 2;
    localparam int MODE_LSB = 0;
    localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
    localparam logic START_RST = 1'b0;
    localparam logic OVERFLOW_IRQ_MASK_RST = 1'b1;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam int PRE_W = 7;

    // ----------------------------------------------------------------
    // interrupt status layout
    // ----------------------------------------------------------------
    localparam int IRQ_W = 2;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam int FLAG_BIT = 0;

    typedef enum logic [1:0] {MODE_FREE, MODE_DOWN, MODE_MODULO, MODE_UPDOWN} count_mode_t;
    typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage : timer_pkg

// File: rtl/timer_prescaler.sv
// Purpose: divides the shared tick into active counting edges
// Assumes: tick is a one-cycle pulse synchronous to clk
// Notes:   the division code is used live, so a new code acts at once
`timescale 1ns/1ps
module timer_prescaler import timer_pkg::*; #(
    parameter int PW = PRE_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic [DIV_W-1:0] div_code,
    output logic edge_pulse
);

    logic [PW-1:0] pre_q;
    logic [PW-1:0] low_mask;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // no restart on a code change: the next edge follows the new rate
    always_comb begin
        low_mask = PW'((1 << div_code) - 1);
        edge_pulse = tick && ((pre_q & low_mask) == low_mask);
    end

    chk_div_one_every: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && div_code == DIV_RST) |-> edge_pulse)
        else $error("divide-by-one tick gave no edge");

endmodule : timer_prescaler

// File: rtl/timer_core.sv
// Purpose: eight-bit timer core with AXI4-Lite register access
// Assumes: TICK is a one-cycle pulse synchronous to CLK
// Notes:   writes act only when byte lane 0 is enabled
`timescale 1ns/1ps
module timer_core import timer_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // timer tick
    input wire logic TICK,
    // write address channel
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // write data channel
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // write response channel
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // read address channel
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // read data channel
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // interrupt
    output logic IRQ
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
    logic [1:0] bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic aw_full_q, w_full_q;
    logic [IDX_W-1:0] wr_idx_q;
    logic [DATA_W-1:0] wdata_q;
    logic wlane_q;
    logic aw_hs, w_hs, ar_hs, do_wr, wr_go;
    logic aw_full_d, w_full_d, bvalid_d, rvalid_d;
    logic wr_ok, rd_ok;
    logic [IDX_W-1:0] rd_idx;
    logic [DATA_W-1:0] rd_data;
    logic ctrl_wr, cc0_wr, flag_wr, stat_wr, mask_wr;
    logic [DIV_W-1:0] div_q;
    logic start_q, overflow_irq_mask_q;
    count_mode_t mode_q, wr_mode;
    logic [7:0] cc0_q, cnt_q, cnt_d;
    count_dir_t dir_q, dir_d;
    logic edge_pulse, ovf, done_ev, flag_q;
    logic [IRQ_W-1:0] stat_q, mask_q, events;

    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RRESP = rresp_q;
    assign RDATA = rdata_q;
    assign IRQ = irq_q;

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    always_comb begin
        aw_hs = AWVALID && awready_q;
        w_hs = WVALID && wready_q;
        ar_hs = ARVALID && arready_q;
        do_wr = aw_full_q && w_full_q && !bvalid_q;
        wr_go = do_wr && wlane_q;
        aw_full_d = (aw_full_q || aw_hs) && !do_wr;
        w_full_d = (w_full_q || w_hs) && !do_wr;
        bvalid_d = do_wr || (bvalid_q && !BREADY);
        rvalid_d = ar_hs || (rvalid_q && !RREADY);
        rd_idx = ARADDR[ADDR_W-1:2];
    end

    // address and data are latched separately so either may come first
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            wr_idx_q <= '0;
            wdata_q <= '0;
            wlane_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= !aw_full_d && !bvalid_d;
            wready_q <= !w_full_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            if (aw_hs) begin
                wr_idx_q <= AWADDR[ADDR_W-1:2];
            end
            if (w_hs) begin
                wdata_q <= WDATA;
                wlane_q <= WSTRB[0];
            end
            if (do_wr) begin
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_wr = 1'b0;
        cc0_wr = 1'b0;
        flag_wr = 1'b0;
        stat_wr = 1'b0;
        mask_wr = 1'b0;
        wr_ok = 1'b1;
        if (wr_idx_q == IDX_CONTROL) begin
            ctrl_wr = wr_go;
        end else if (wr_idx_q == IDX_CC0) begin
            cc0_wr = wr_go;
        end else if (wr_idx_q == IDX_FLAG) begin
            flag_wr = wr_go;
        end else if (wr_idx_q == IDX_IRQ_STATUS) begin
            stat_wr = wr_go;
        end else if (wr_idx_q == IDX_IRQ_MASK) begin
            mask_wr = wr_go;
        end else if (wr_idx_q != IDX_COUNT) begin
            wr_ok = 1'b0;
        end
        wr_mode = count_mode_t'(wdata_q[MODE_LSB +: 2]);
    end

    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        if (rd_idx == IDX_COUNT) begin
            rd_data[7:0] = cnt_q;
        end else if (rd_idx == IDX_CONTROL) begin
            // clear is never stored, so it reads zero also after any write
            rd_data[7:0] = {div_q, start_q, overflow_irq_mask_q, 1'b0, mode_q};
        end else if (rd_idx == IDX_CC0) begin
            rd_data[7:0] = cc0_q;
        end else if (rd_idx == IDX_FLAG) begin
            rd_data[FLAG_BIT] = flag_q;
        end else if (rd_idx == IDX_IRQ_STATUS) begin
            rd_data[IRQ_W-1:0] = stat_q;
        end else if (rd_idx == IDX_IRQ_MASK) begin
            rd_data[IRQ_W-1:0] = mask_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs) begin
                rdata_q <= rd_data;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // control and compare registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            div_q <= DIV_RST;
            start_q <= START_RST;
            overflow_irq_mask_q <= OVERFLOW_IRQ_MASK_RST;
            mode_q <= MODE_FREE;
        end else if (ctrl_wr) begin
            div_q <= wdata_q[DIV_LSB +: DIV_W];
            start_q <= wdata_q[START_BIT];
            overflow_irq_mask_q <= wdata_q[OVERFLOW_IRQ_MASK_BIT];
            mode_q <= wr_mode;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cc0_q <= COUNT_ZERO;
        end else if (cc0_wr) begin
            cc0_q <= wdata_q[7:0];
        end
    end

    timer_prescaler #(
        .PW(PRE_W)
    ) u_prescaler (
        .clk(CLK),
        .rst_b(RST_B),
        .tick(TICK),
        .div_code(div_q),
        .edge_pulse(edge_pulse)
    );

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        ovf = 1'b0;
        if (ctrl_wr && wdata_q[CLR_BIT]) begin
            cnt_d = COUNT_ZERO;
            dir_d = DIR_UP;
        end else if (ctrl_wr && wr_mode == MODE_DOWN && mode_q != MODE_DOWN) begin
            cnt_d = cc0_q;
        end else if (start_q && edge_pulse) begin
            case (mode_q)
                MODE_FREE: begin
                    cnt_d = cnt_q + 1'b1;
                    ovf = (cnt_q == COUNT_MAX);
                end
                MODE_DOWN: begin
                    if (cnt_q != COUNT_ZERO) begin
                        cnt_d = cnt_q - 1'b1;
                        ovf = (cnt_q == COUNT_ONE);
                    end
                end
                MODE_MODULO: begin
                    // >= so a compare lowered below the count still wraps
                    if (cnt_q >= cc0_q) begin
                        cnt_d = COUNT_ZERO;
                        ovf = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                default: begin
                    case (dir_q)
                        DIR_UP: begin
                            if (cnt_q >= cc0_q) begin
                                if (cc0_q != COUNT_ZERO) begin
                                    cnt_d = cnt_q - 1'b1;
                                    dir_d = DIR_DOWN;
                                end
                            end else begin
                                cnt_d = cnt_q + 1'b1;
                            end
                        end
                        default: begin
                            if (cnt_q <= COUNT_ONE) begin
                                cnt_d = COUNT_ZERO;
                                dir_d = DIR_UP;
                                ovf = (cnt_q == COUNT_ONE);
                            end else begin
                                cnt_d = cnt_q - 1'b1;
                            end
                        end
                    endcase
                end
            endcase
        end
        done_ev = ovf && (mode_q == MODE_DOWN);
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt_q <= COUNT_ZERO;
            dir_q <= DIR_UP;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // ----------------------------------------------------------------
    // pending flag and interrupts
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[IRQ_OVF_BIT] = ovf && overflow_irq_mask_q;
        events[IRQ_DONE_BIT] = done_ev;
    end

    // set wins over any clear arriving in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            flag_q <= 1'b0;
            stat_q <= '0;
            mask_q <= IRQ_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            flag_q <= ovf || (flag_q && !(flag_wr && !wdata_q[FLAG_BIT]));
            stat_q <= events | (stat_q & ~(stat_wr ? wdata_q[IRQ_W-1:0] : '0));
            if (mask_wr) begin
                mask_q <= wdata_q[IRQ_W-1:0];
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_ctrl_write(int b);
        ctrl_wr && wdata_q[b];
    endsequence

    chk_count_readback: assert property (
        (ar_hs && rd_idx == IDX_COUNT) |=> (RDATA[7:0] == $past(cnt_q) && RVALID))
        else $error("count read does not show the live count");
    chk_clear_zeroes: assert property (
        s_ctrl_write(CLR_BIT) |=> (cnt_q == COUNT_ZERO))
        else $error("clear write did not zero the count");
    chk_clear_reads_zero: assert property (
        (ar_hs && rd_idx == IDX_CONTROL) |=> !RDATA[CLR_BIT])
        else $error("clear bit read back as one");
    chk_suspend_hold: assert property (
        (!start_q && !ctrl_wr) |=> $stable(cnt_q))
        else $error("count moved while suspended");
    chk_free_wrap: assert property (
        (mode_q == MODE_FREE && start_q && edge_pulse && !ctrl_wr && cnt_q == COUNT_MAX)
        |=> (cnt_q == COUNT_ZERO && flag_q))
        else $error("free mode did not wrap to zero");
    chk_down_stops: assert property (
        (mode_q == MODE_DOWN && cnt_q == COUNT_ZERO && !ctrl_wr) |=> (cnt_q == COUNT_ZERO))
        else $error("down mode moved past zero");
    chk_modulo_wrap: assert property (
        (mode_q == MODE_MODULO && start_q && edge_pulse && !ctrl_wr && cnt_q == cc0_q)
        |=> (cnt_q == COUNT_ZERO))
        else $error("modulo mode did not restart at compare");
    chk_updown_turn: assert property (
        (mode_q == MODE_UPDOWN && dir_q == DIR_UP && start_q && edge_pulse && !ctrl_wr
            && cnt_q == cc0_q && cc0_q != COUNT_ZERO)
        |=> (cnt_q == $past(cc0_q) - COUNT_ONE && dir_q == DIR_DOWN))
        else $error("up/down mode did not turn at compare");
    chk_mask_blocks: assert property (
        (ovf && !overflow_irq_mask_q && !stat_q[IRQ_OVF_BIT]) |=> !stat_q[IRQ_OVF_BIT])
        else $error("masked overflow reached interrupt status");
    chk_flag_one_write: assert property (
        (flag_wr && wdata_q[FLAG_BIT] && !flag_q && !ovf) |=> !flag_q)
        else $error("writing one set the pending flag");
    chk_irq_follows: assert property (
        (|(stat_q & mask_q)) |=> IRQ)
        else $error("interrupt output missed a pending status bit");

endmodule : timer_core

// File: test/timer_core_bench.sv
// Purpose: self-checking bench for the eight-bit timer core over its register bus
// Assumes: ticks are driven by hand so every count is predictable
// Notes:   bus ready flags are sampled at the falling edge; they are registered, so stable
`timescale 1ns/1ps
module timer_core_bench import timer_pkg::*;;
    // ------------------------------------------------------------------
    // clock, reset and design ports
    // ------------------------------------------------------------------
    logic CLK, RST_B, TICK;
    logic [ADDR_W-1:0] AWADDR, ARADDR;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [DATA_W-1:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic IRQ;
    int error_cnt = 0;
    int comparisons = 0;

    timer_core uut (.CLK(CLK), .RST_B(RST_B), .TICK(TICK), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .IRQ(IRQ));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_up();
        error_cnt++;
        $display("ERROR at %0t: got %h expected %h (bus hang)", $time, 32'h0, 32'h1);
        finish_test();
    endtask : give_up

    // write one word; both channels offered together, response checked
    task automatic wrc(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [1:0] er,
                       input logic [3:0] ws = 4'hF);
        logic aw_p, w_p, hit_aw, hit_w, hit_b, done;
        logic [1:0] resp;
        int n;
        @(posedge CLK);
        AWADDR <= {idx, 2'h0};
        WDATA <= d;
        WSTRB <= ws;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        done = 1'b0;
        n = 0;
        while (!done) begin
            @(negedge CLK);
            hit_aw = aw_p && AWREADY;
            hit_w = w_p && WREADY;
            hit_b = !aw_p && !w_p && BVALID;
            resp = BRESP;
            @(posedge CLK);
            if (hit_aw) begin
                AWVALID <= 1'b0;
                aw_p = 1'b0;
            end
            if (hit_w) begin
                WVALID <= 1'b0;
                w_p = 1'b0;
            end
            if (hit_b) begin
                BREADY <= 1'b0;
                done = 1'b1;
            end
            n++;
            if (n > 100) give_up();
        end
        check({30'h0, resp}, {30'h0, er});
    endtask : wrc

    // read one word and compare data and response
    task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp,
                       input logic [1:0] er = RESP_OKAY);
        logic ar_p, hit_ar, hit_r, done;
        logic [31:0] data;
        logic [1:0] resp;
        int n;
        @(posedge CLK);
        ARADDR <= {idx, 2'h0};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        ar_p = 1'b1;
        done = 1'b0;
        n = 0;
        while (!done) begin
            @(negedge CLK);
            hit_ar = ar_p && ARREADY;
            hit_r = !ar_p && RVALID;
            data = RDATA;
            resp = RRESP;
            @(posedge CLK);
            if (hit_ar) begin
                ARVALID <= 1'b0;
                ar_p = 1'b0;
            end
            if (hit_r) begin
                RREADY <= 1'b0;
                done = 1'b1;
            end
            n++;
            if (n > 100) give_up();
        end
        check(data, exp);
        check({30'h0, resp}, {30'h0, er});
    endtask : rdc

    // one-cycle tick pulses with an idle cycle between them
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge CLK);
            TICK <= 1'b1;
            @(posedge CLK);
            TICK <= 1'b0;
        end
        @(posedge CLK);
    endtask : ticks

    function automatic logic [31:0] ctl(input logic [2:0] dv, input logic st, input logic om,
                                        input logic cl, input logic [1:0] md);
        return {24'h0, dv, st, om, cl, md};
    endfunction : ctl

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_CONTROL, 32'h08);
        rdc(IDX_CC0, 32'h0);
        rdc(IDX_FLAG, 32'h0);
        rdc(10'h0EC, 32'h0, RESP_SLVERR);
        wrc(10'h0EC, 32'hFF, RESP_SLVERR);
        check({31'h0, IRQ}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_free();
        wrc(IDX_CONTROL, ctl(0, 0, 1, 0, 0), RESP_OKAY);
        ticks(3);
        rdc(IDX_COUNT, 32'h0);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 0, 0), RESP_OKAY);
        ticks(5);
        rdc(IDX_COUNT, 32'h05);
        wrc(IDX_COUNT, 32'h55, RESP_OKAY);
        rdc(IDX_COUNT, 32'h05);
        wrc(IDX_CONTROL, ctl(0, 0, 1, 0, 0), RESP_OKAY);
        ticks(4);
        rdc(IDX_COUNT, 32'h05);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 0, 0), RESP_OKAY);
        ticks(251);
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_FLAG, 32'h1);
        wrc(IDX_FLAG, 32'h1, RESP_OKAY);
        rdc(IDX_FLAG, 32'h1);
        wrc(IDX_FLAG, 32'h0, RESP_OKAY);
        rdc(IDX_FLAG, 32'h0);
        // a one written to a clear flag must not set it
        wrc(IDX_FLAG, 32'h1, RESP_OKAY);
        rdc(IDX_FLAG, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'h1);
        check({31'h0, IRQ}, 32'h0);
        wrc(IDX_IRQ_MASK, 32'h3, RESP_OKAY);
        // the output follows the mask one edge later, so look once it has settled
        @(negedge CLK);
        check({31'h0, IRQ}, 32'h1);
        wrc(IDX_IRQ_STATUS, 32'h1, RESP_OKAY);
        rdc(IDX_IRQ_STATUS, 32'h0);
        check({31'h0, IRQ}, 32'h0);
        $display("test free running done");
    endtask : t_free

    task automatic t_clear();
        ticks(7);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 0, 0), RESP_OKAY);
        rdc(IDX_COUNT, 32'h07);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 1, 0), RESP_OKAY);
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_CONTROL, ctl(0, 1, 1, 0, 0));
        $display("test clear done");
    endtask : t_clear

    // a whole number of prescaler periods makes the result phase independent
    task automatic t_div();
        wrc(IDX_CONTROL, ctl(2, 1, 1, 1, 0), RESP_OKAY);
        ticks(8);
        rdc(IDX_COUNT, 32'h02);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 0, 0), RESP_OKAY);
        ticks(3);
        rdc(IDX_COUNT, 32'h05);
        wrc(IDX_CONTROL, ctl(7, 1, 1, 0, 0), RESP_OKAY);
        rdc(IDX_CONTROL, ctl(7, 1, 1, 0, 0));
        ticks(128);
        rdc(IDX_COUNT, 32'h06);
        $display("test prescaler done");
    endtask : t_div

    task automatic t_modes();
        wrc(IDX_CC0, 32'h03, RESP_OKAY);
        rdc(IDX_CC0, 32'h03);
        // lane 0 disabled: the write is answered but must leave the compare alone
        wrc(IDX_CC0, 32'h07, RESP_OKAY, 4'hE);
        rdc(IDX_CC0, 32'h03);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 1, 2), RESP_OKAY);
        ticks(5);
        rdc(IDX_COUNT, 32'h01);
        rdc(IDX_IRQ_STATUS, 32'h1);
        wrc(IDX_IRQ_STATUS, 32'h3, RESP_OKAY);
        wrc(IDX_CONTROL, ctl(0, 1, 0, 1, 2), RESP_OKAY);
        ticks(4);
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'h0);
        check({31'h0, IRQ}, 32'h0);
        wrc(IDX_CC0, 32'h02, RESP_OKAY);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 1, 3), RESP_OKAY);
        ticks(3);
        rdc(IDX_COUNT, 32'h01);
        ticks(1);
        rdc(IDX_COUNT, 32'h0);
        wrc(IDX_IRQ_STATUS, 32'h3, RESP_OKAY);
        wrc(IDX_CC0, 32'h05, RESP_OKAY);
        wrc(IDX_CONTROL, ctl(0, 1, 1, 0, 1), RESP_OKAY);
        rdc(IDX_COUNT, 32'h05);
        ticks(3);
        rdc(IDX_COUNT, 32'h02);
        ticks(4);
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'h3);
        check({31'h0, IRQ}, 32'h1);
        $display("test counting modes done");
    endtask : t_modes

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        RST_B = 1'b0;
        TICK = 1'b0;
        AWADDR = '0;
        ARADDR = '0;
        WDATA = '0;
        WSTRB = 4'h0;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        BREADY = 1'b0;
        ARVALID = 1'b0;
        RREADY = 1'b0;
        repeat (5) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        t_reset();
        t_free();
        t_clear();
        t_div();
        t_modes();
        finish_test();
    end
endmodule : timer_core_bench
